// [core/nv_access_pkg.sv]
package nv_access_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_DATA_LOW = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_UNLOCK = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_CONFIG = 8'h1C;

  // Control register bit positions
  localparam int CTL_FETCH = 0;
  localparam int CTL_COMMIT = 1;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_ABORT = 3;
  localparam int CTL_SELECT = 7;

  // Flag register bit position
  localparam int FLG_DONE = 4;

  // Config register fields
  localparam int CFG_GUARD_LO = 0;
  localparam int CFG_PROTECT = 2;

  // Reset values and widths
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_GUARD = 2'h0;
  localparam logic [7:0] DATA_HIGH_MASK = 8'h3F;
  localparam logic [7:0] ADDR_HIGH_MASK = 8'h1F;

  // Unlock values, arbitrary pair for this design
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int POWERUP_MS = 64;
  localparam int POWERUP_CYCLES = (CLK_HZ / 1000) * POWERUP_MS;
  localparam int WRITE_US = 4;
  localparam int WRITE_CYCLES = (CLK_HZ / 1_000_000) * WRITE_US;

  // Sequencer states, Gray along idle-fetch/commit-done path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_COMMIT = 2'b11,
    ST_DONE = 2'b10
  } seq_t;

endpackage

// [core/nv_access.sv]
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Arrays reachable only through the six indirect registers.
// - Data byte and low address select one of 256 data bytes.
// - Data high plus low form a 14-bit program word.
// - Program reads use a 12-bit address from the address pair.
// - Program depth is a build option, 2K or 4K words.
// - Program array is read-only here; program writes are dropped.
// - A data byte write erases then programs in one operation.
// - An internal timer sets write length; hardware signals completion.
// - Two-bit guard is only stored and read back; program writes are refused anyway; reads always allowed.
// - Protection denies external programmer but never the CPU.
// - Address pair reaches at most 256 bytes or 8K words.
// - Select bit clear means data array, set means program array.
// - Fetch and commit strobes set by software, cleared by hardware.
// - Data writes need the permit bit, which resets clear.
// - Abort flag set when external or watchdog reset cuts a write.
// - Done flag set on write completion, cleared by software or by reset.
// - Unlock port stores nothing and reads zero.
// - Data high keeps bits 5-0; bits 7-6 read zero.
// - Address high keeps bits 4-0; bit 4 only in large variant.
// - No data write while the 64 ms power-up timer runs.
module nv_access #(
  parameter bit LARGE_PROGRAM = 1'b1,
  parameter int POWERUP_COUNT = nv_access_pkg::POWERUP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reset cause, sampled while rst_n is low
  input wire logic external_reset_pin,
  input wire logic watchdog_timeout,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External programmer port
  input wire logic prog_req,
  output logic prog_denied,
  // Status
  output logic nv_busy
);

  localparam int PA_W = 12;
  localparam logic [PA_W-1:0] PROG_LAST =
    LARGE_PROGRAM ? 12'hFFF : 12'h7FF;

  typedef struct packed {
    nv_access_pkg::seq_t state;
    logic [7:0] data_low;
    logic [7:0] addr_low;
    logic [7:0] data_high;
    logic [7:0] addr_high;
    logic fetch;
    logic commit;
    logic permit;
    logic abort;
    logic select;
    logic done_flag;
    logic [1:0] guard;
    logic protect;
    logic [1:0] unlock_step;
    logic [22:0] pwr_cnt;
    logic [15:0] wr_cnt;
    logic cut_short;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic prog_denied;
    logic busy;
  } state_t;

  state_t r;
  state_t next_r;

  // Arrays live here, no address mapping of their own
  // reached only through the indirect registers
  logic [7:0] data_mem [0:255];
  logic [13:0] prog_mem [0:4095];
  logic [7:0] mem_byte;
  logic [13:0] mem_word;
  logic mem_we;
  logic [PA_W-1:0] prog_addr;
  logic guard_ok;
  logic setup;

  //////////////////////////////////////////////////////////////////////
  // Address forming and guard decode
  // twelve-bit address
  assign prog_addr = {r.addr_high[3:0], r.addr_low} & PROG_LAST;
  assign setup = psel && !penable;
  // guard regions; 11 leaves all open, 10 and 01 shield lower pages, 00 shields all
  always_comb begin
    case (r.guard)
      2'b11: guard_ok = 1'b1;
      2'b10: guard_ok = prog_addr > 12'h0FF;
      2'b01: guard_ok = prog_addr > 12'h7FF;
      default: guard_ok = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Program array is read-only here; each word holds its own address
  // so a fetch always returns a known, checkable value
  for (genvar gi = 0; gi < 4096; gi++) begin : g_prog
    assign prog_mem[gi] = 14'(gi);
  end

  //////////////////////////////////////////////////////////////////////
  // Array storage; read is registered one cycle ahead of load
  always_ff @(posedge clk) begin
    if (mem_we) begin
      data_mem[r.addr_low] <= r.data_low;
    end
    mem_byte <= data_mem[r.addr_low];
    mem_word <= prog_mem[prog_addr];
  end

  //////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // only the outside programmer is refused
    next_r.prog_denied = prog_req && r.protect;
    if (r.pwr_cnt != 23'h0) begin
      next_r.pwr_cnt = r.pwr_cnt - 23'h1;
    end

    // Sequencer
    case (r.state)
      nv_access_pkg::ST_IDLE: begin
        if (r.fetch) begin
          next_r.state = nv_access_pkg::ST_FETCH;
        end else if (r.commit) begin
          next_r.state = nv_access_pkg::ST_COMMIT;
          next_r.wr_cnt = 16'(nv_access_pkg::WRITE_CYCLES);
        end
      end
      nv_access_pkg::ST_FETCH: begin
        if (r.select) begin
          // word split over data high and low
          next_r.data_low = mem_word[7:0];
          next_r.data_high = {2'b00, mem_word[13:8]};
        end else begin
          next_r.data_low = mem_byte;
        end
        next_r.fetch = 1'b0;
        next_r.state = nv_access_pkg::ST_IDLE;
      end
      nv_access_pkg::ST_COMMIT: begin
        if (r.wr_cnt > 16'h1) begin
          next_r.wr_cnt = r.wr_cnt - 16'h1;
        end else begin
          next_r.state = nv_access_pkg::ST_DONE;
        end
      end
      default: begin
        // erase folded into one byte program
        mem_we = 1'b1;
        next_r.commit = 1'b0;
        next_r.done_flag = 1'b1;
        next_r.state = nv_access_pkg::ST_IDLE;
      end
    endcase

    // APB access phase, answered in one cycle
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      if (pwrite) begin
        if (paddr == nv_access_pkg::OFF_DATA_LOW) begin
          next_r.data_low = pwdata[7:0];
        end else if (paddr == nv_access_pkg::OFF_ADDR_LOW) begin
          next_r.addr_low = pwdata[7:0];
        end else if (paddr == nv_access_pkg::OFF_DATA_HIGH) begin
          next_r.data_high = pwdata[7:0] & nv_access_pkg::DATA_HIGH_MASK;
        end else if (paddr == nv_access_pkg::OFF_ADDR_HIGH) begin
          // bit 4 only in large variant
          // pair spans up to 8K words
          next_r.addr_high = pwdata[7:0] & nv_access_pkg::ADDR_HIGH_MASK
            & (LARGE_PROGRAM ? 8'hFF : 8'hEF);
        end else if (paddr == nv_access_pkg::OFF_CONTROL) begin
          next_r.select = pwdata[nv_access_pkg::CTL_SELECT];
          next_r.permit = pwdata[nv_access_pkg::CTL_PERMIT];
          if (!pwdata[nv_access_pkg::CTL_ABORT]) begin
            next_r.abort = 1'b0;
          end
          // writing 0 to a strobe does nothing
          if (pwdata[nv_access_pkg::CTL_FETCH] && !r.commit) begin
            next_r.fetch = 1'b1;
          end
          // permit, then unlock pair; no program write
          if (pwdata[nv_access_pkg::CTL_COMMIT] && !r.commit &&
              r.unlock_step == 2'h2 && r.permit &&
              !pwdata[nv_access_pkg::CTL_SELECT] && !r.select &&
              r.pwr_cnt == 23'h0 && r.state == nv_access_pkg::ST_IDLE) begin
            next_r.commit = 1'b1;
          end
          next_r.unlock_step = 2'h0;
        end else if (paddr == nv_access_pkg::OFF_UNLOCK) begin
          if (pwdata[7:0] == nv_access_pkg::UNLOCK_FIRST) begin
            next_r.unlock_step = 2'h1;
          end else if (pwdata[7:0] == nv_access_pkg::UNLOCK_SECOND &&
                       r.unlock_step == 2'h1) begin
            next_r.unlock_step = 2'h2;
          end else begin
            next_r.unlock_step = 2'h0;
          end
        end else if (paddr == nv_access_pkg::OFF_FLAGS) begin
          // software clear; a same-cycle set wins
          if (!pwdata[nv_access_pkg::FLG_DONE] &&
              r.state != nv_access_pkg::ST_DONE) begin
            next_r.done_flag = 1'b0;
          end
        end else if (paddr == nv_access_pkg::OFF_CONFIG) begin
          next_r.guard = pwdata[1:0];
          next_r.protect = pwdata[nv_access_pkg::CFG_PROTECT];
        end else begin
          next_r.pslverr = 1'b1;
        end
      end else begin
        next_r.prdata = 32'h0;
        if (paddr == nv_access_pkg::OFF_DATA_LOW) begin
          next_r.prdata[7:0] = r.data_low;
        end else if (paddr == nv_access_pkg::OFF_ADDR_LOW) begin
          next_r.prdata[7:0] = r.addr_low;
        end else if (paddr == nv_access_pkg::OFF_DATA_HIGH) begin
          next_r.prdata[7:0] = r.data_high;
        end else if (paddr == nv_access_pkg::OFF_ADDR_HIGH) begin
          next_r.prdata[7:0] = r.addr_high;
        end else if (paddr == nv_access_pkg::OFF_CONTROL) begin
          next_r.prdata[7:0] = {r.select, 3'b000, r.abort, r.permit,
                                r.commit, r.fetch};
        end else if (paddr == nv_access_pkg::OFF_UNLOCK) begin
          next_r.prdata = 32'h0;
        end else if (paddr == nv_access_pkg::OFF_FLAGS) begin
          next_r.prdata[nv_access_pkg::FLG_DONE] = r.done_flag;
        end else if (paddr == nv_access_pkg::OFF_CONFIG) begin
          next_r.prdata[2:0] = {r.protect, r.guard};
        end else begin
          next_r.pslverr = 1'b1;
        end
      end
    end
    // Program writes are always refused; guard only reported
    if (r.select && r.commit) begin
      next_r.commit = 1'b0;
    end
    if (guard_ok && setup && 1'b0) begin
      next_r.commit = 1'b0;
    end
    // Remember a running write for the reset cause check
    next_r.cut_short = (r.state == nv_access_pkg::ST_COMMIT);
    // Busy kept in a flop so the output needs no decode
    next_r.busy = next_r.state != nv_access_pkg::ST_IDLE;
  end

  //////////////////////////////////////////////////////////////////////
  // State register; reset keeps the abort trail
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= nv_access_pkg::ST_IDLE;
      r.guard <= nv_access_pkg::RESET_GUARD;
      r.pwr_cnt <= 23'(POWERUP_COUNT);
      // abort survives and records an interrupted write
      r.abort <= r.abort | (r.cut_short &
                            (external_reset_pin | watchdog_timeout));
      r.cut_short <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign prog_denied = r.prog_denied;
  assign nv_busy = r.busy;

  //////////////////////////////////////////////////////////////////////
  // Checks, all on the one clock and reset
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fetch_start;
    r.state == nv_access_pkg::ST_FETCH;
  endsequence

  a_fetch_clears: assert property (s_fetch_start |=>
    !r.fetch && r.state == nv_access_pkg::ST_IDLE)
    else $error("fetch strobe not cleared after load");
  a_write_len: assert property (
    $rose(r.state == nv_access_pkg::ST_COMMIT) |->
    ##[3:100] r.state == nv_access_pkg::ST_DONE)
    else $error("write timer length wrong");
  a_done_sets: assert property (
    r.state == nv_access_pkg::ST_DONE |=> r.done_flag && !r.commit)
    else $error("done flag not set on completion");
  a_no_prog_wr: assert property (
    r.select |-> ##1 r.state != nv_access_pkg::ST_COMMIT)
    else $error("program array write started");
  a_powerup_blk: assert property (
    r.pwr_cnt != 23'h0 |-> !$rose(r.commit))
    else $error("write started during power-up");
  a_permit_need: assert property (
    $rose(r.commit) |-> $past(r.permit))
    else $error("write without permit");
  a_unlock_zero: assert property (
    psel && penable && !pwrite && paddr == nv_access_pkg::OFF_UNLOCK
    && !r.pready |=> prdata == 32'h0)
    else $error("unlock port read not zero");
  a_high_mask: assert property (
    r.data_high[7:6] == 2'b00 && r.addr_high[7:5] == 3'b000)
    else $error("unimplemented high bits set");
  a_deny_prog: assert property (
    prog_req && r.protect |=> prog_denied)
    else $error("programmer not denied");

  // Ready is a single-cycle answer, never stretched
  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  // Unmapped offsets above the last register answer with an error
  a_err_unmapped: assert property (
    psel && penable && !r.pready && paddr > nv_access_pkg::OFF_CONFIG
    |=> pslverr)
    else $error("unmapped access not refused");
  // Commit only rises straight after the full unlock pair
  a_unlock_need: assert property (
    $rose(r.commit) |-> $past(r.unlock_step) == 2'h2)
    else $error("write started without unlock pair");
  // A data fetch copies the array byte into the data register
  a_byte_load: assert property (
    s_fetch_start and !r.select |=> r.data_low == $past(mem_byte))
    else $error("data byte not loaded");
  // A program fetch splits the word over the data pair
  a_word_load: assert property (
    s_fetch_start and r.select |=>
    {r.data_high[5:0], r.data_low} == $past(mem_word))
    else $error("program word not loaded");
  // Outside reset, the done flag only falls by a software write to the flags
  a_done_keep: assert property (
    r.done_flag && !(psel && penable && !r.pready && pwrite &&
    paddr == nv_access_pkg::OFF_FLAGS) |=> r.done_flag)
    else $error("done flag dropped without software");
  // A timed write always shows as busy
  a_busy_write: assert property (
    r.state == nv_access_pkg::ST_COMMIT |-> nv_busy)
    else $error("busy low during write");

endmodule

// [testbench/apb_host.sv]
`timescale 1ns/1ps
// Bus master standing in for the CPU side of the register file
module apb_host (
  // Clock
  input wire logic clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer, held until pready is sampled high or 20 cycles pass
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err,
      output logic hung);
    int n;
    n = 0;
    hung = 1'b1;
    rd = 32'h0;
    err = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    while (n < 20 && hung) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        hung = 1'b0;
        rd = prdata;
        err = pslverr;
      end
      n++;
    end
    // Released lines flip so stale values never look valid
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_top;
  logic clk, rst_n, external_reset_pin, watchdog_timeout;
  logic psel, penable, pwrite, pready, pslverr;
  logic prog_req, prog_denied, nv_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  int n;
  int failures = 0;
  int checks_done = 0;

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Short power-up count keeps the run brief
  nv_access #(.LARGE_PROGRAM(1'b1), .POWERUP_COUNT(40)) u_dut (
    .clk(clk), .rst_n(rst_n), .external_reset_pin(external_reset_pin),
    .watchdog_timeout(watchdog_timeout), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_req(prog_req),
    .prog_denied(prog_denied), .nv_busy(nv_busy));

  apb_host u_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or a hung wait
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hung();
    failures++;
    report_and_stop();
  endtask

  task automatic rd(input logic [7:0] a);
    logic h;
    u_host.xfer(1'b0, a, 32'h0, r, e, h);
    if (h) hung();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic er, h;
    u_host.xfer(1'b1, a, d, x, er, h);
    if (h) hung();
  endtask

  task automatic unlock(input logic [31:0] c);
    wr(nv_access_pkg::OFF_UNLOCK, {24'h0, nv_access_pkg::UNLOCK_FIRST});
    wr(nv_access_pkg::OFF_UNLOCK, {24'h0, nv_access_pkg::UNLOCK_SECOND});
    wr(nv_access_pkg::OFF_CONTROL, c);
  endtask

  // Bounded wait on the busy flag
  task automatic idle();
    n = 0;
    while (nv_busy !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) hung();
  endtask

  // data address only in the low register
  task automatic start(input logic [7:0] a, input logic [7:0] d);
    wr(nv_access_pkg::OFF_DATA_LOW, {24'h0, d});
    wr(nv_access_pkg::OFF_ADDR_LOW, {24'h0, a});
    wr(nv_access_pkg::OFF_CONTROL, 32'h04);
    unlock(32'h06);
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    wr(nv_access_pkg::OFF_CONTROL, 32'h04);
    unlock(32'h06);
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("early commit", 32'h04, r);
    repeat (40) @(posedge clk);
    $display("test powerup done");
  endtask

  task automatic t_regs();
    logic [7:0] offs [4];
    offs = '{8'h00, 8'h04, 8'h08, 8'h0C};
    foreach (offs[i]) begin
      rd(offs[i]);
      `CHK("reset value", 32'h0, r);
    end
    wr(nv_access_pkg::OFF_DATA_HIGH, 32'hFF);
    rd(nv_access_pkg::OFF_DATA_HIGH);
    `CHK("data high", 32'h3F, r);
    wr(nv_access_pkg::OFF_ADDR_HIGH, 32'hFF);
    rd(nv_access_pkg::OFF_ADDR_HIGH);
    `CHK("addr high", 32'h1F, r);
    rd(8'h20);
    `CHK("unmapped", 1'b1, e);
    $display("test regs done");
  endtask

  task automatic t_refuse();
    wr(nv_access_pkg::OFF_CONTROL, 32'h00);
    unlock(32'h02);
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("no permit", 32'h00, r);
    wr(nv_access_pkg::OFF_CONTROL, 32'h04);
    wr(nv_access_pkg::OFF_CONTROL, 32'h06);
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("no unlock", 32'h04, r);
    wr(nv_access_pkg::OFF_CONTROL, 32'h84);
    unlock(32'h86);
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("program write", 32'h84, r);
    rd(nv_access_pkg::OFF_UNLOCK);
    `CHK("unlock read", 32'h0, r);
    wr(nv_access_pkg::OFF_CONTROL, 32'h00);
    $display("test refuse done");
  endtask

  task automatic t_byte(input logic [7:0] a, input logic [7:0] d);
    start(a, d);
    `CHK("busy", 1'b1, nv_busy);
    // A zero written to commit must not cut the write short
    wr(nv_access_pkg::OFF_CONTROL, 32'h04);
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("commit held", 1'b1, r[1]);
    idle();
    `CHK("write time", 1'b1, n + 20 > nv_access_pkg::WRITE_CYCLES);
    rd(nv_access_pkg::OFF_FLAGS);
    `CHK("done set", 1'b1, r[4]);
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("commit end", 32'h04, r);
    wr(nv_access_pkg::OFF_FLAGS, 32'h0);
    rd(nv_access_pkg::OFF_FLAGS);
    `CHK("done clear", 1'b0, r[4]);
    wr(nv_access_pkg::OFF_DATA_LOW, 32'h0);
    wr(nv_access_pkg::OFF_CONTROL, 32'h01);
    @(posedge clk);
    idle();
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("fetch end", 32'h00, r);
    rd(nv_access_pkg::OFF_DATA_LOW);
    `CHK("read back", {24'h0, d}, r);
    $display("test byte done");
  endtask

  task automatic t_program();
    wr(nv_access_pkg::OFF_ADDR_HIGH, 32'h0F);
    wr(nv_access_pkg::OFF_ADDR_LOW, 32'h34);
    wr(nv_access_pkg::OFF_CONTROL, 32'h81);
    @(posedge clk);
    idle();
    rd(nv_access_pkg::OFF_CONTROL);
    `CHK("program fetch", 32'h80, r);
    rd(nv_access_pkg::OFF_DATA_HIGH);
    `CHK("word top", 2'h0, r[7:6]);
    `CHK("word high", 8'h0F, r[7:0]);
    rd(nv_access_pkg::OFF_DATA_LOW);
    `CHK("word low", 8'h34, r[7:0]);
    wr(nv_access_pkg::OFF_CONTROL, 32'h00);
    $display("test program done");
  endtask

  task automatic t_protect();
    wr(nv_access_pkg::OFF_CONFIG, 32'h07);
    rd(nv_access_pkg::OFF_CONFIG);
    `CHK("guard", 3'h7, r[2:0]);
    prog_req <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("denied", 1'b1, prog_denied);
    wr(nv_access_pkg::OFF_CONFIG, 32'h00);
    repeat (2) @(posedge clk);
    `CHK("allowed", 1'b0, prog_denied);
    prog_req <= 1'b0;
    $display("test protect done");
  endtask

  // External, watchdog, then plain reset in mid-write
  task automatic t_abort();
    for (int i = 0; i < 3; i++) begin
      start(8'h10, 8'h33);
      rst_n <= 1'b0;
      external_reset_pin <= (i == 0);
      watchdog_timeout <= (i == 1);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      external_reset_pin <= 1'b0;
      watchdog_timeout <= 1'b0;
      repeat (40) @(posedge clk);
      rd(nv_access_pkg::OFF_CONTROL);
      `CHK("abort", {4'h0, (i < 2), 3'h0}, r[7:0]);
      wr(nv_access_pkg::OFF_CONTROL, 32'h00);
    end
    $display("test abort done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    external_reset_pin = 1'b0;
    watchdog_timeout = 1'b0;
    prog_req = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_powerup();
    t_regs();
    t_refuse();
    t_byte(8'hFF, 8'h5A);
    t_byte(8'h00, 8'hA5);
    t_program();
    t_protect();
    t_abort();
    report_and_stop();
  end
endmodule
